/* logic/urb_cfg.svh */
// offsets, field positions, reset values and timing counts of the receive block
// assumes a 32-bit apb bus with byte addresses and one word per register
// Contract
// - data read advances buffer, flags follow
// - complete flag set while unread character buffered
// - receiver disable empties buffer, clears complete
// - interrupt requested while flag and enable set
// - error flags stored and presented with frame
// - writes to error flag bits ignored
// - error flags never raise interrupts
// - frame error mirrors first stop bit, inverted
// - stop bit count setting ignored by check
// - overrun when buffer full, shifter full, start
// - overrun cleared on successful buffer transfer
// - parity error zero while checking disabled
// - odd or even parity checked on data
// - parity error kept until data read
// - receiver disable abandons frame at once
// - disabled receiver releases the receive pin
// - shift after start, store on first stop
// - unused upper data bits read zero
`ifndef URB_CFG_SVH
`define URB_CFG_SVH

`define URB_OFS_STATUS   8'h00
`define URB_OFS_CTRL_B   8'h04
`define URB_OFS_CTRL_C   8'h08
`define URB_OFS_DATA     8'h0c
`define URB_OFS_BAUD     8'h10

`define URB_STA_RXC      7
`define URB_STA_FE       4
`define URB_STA_DOR      3
`define URB_STA_UPE      2

`define URB_CB_IRQ_EN    7
`define URB_CB_RX_EN     4
`define URB_CB_RX9       1
`define URB_CB_TX9       0

`define URB_CC_PAR_EN    5
`define URB_CC_PAR_ODD   4
`define URB_CC_STOP_SEL  3
`define URB_CC_SIZE_LO   0

`define URB_CC_SIZE_RST  3'h3
`define URB_SIZE_NINE    3'h7
`define URB_BAUD_RST     16'h0411

`endif

/* logic/urb_pkg.sv */
// types shared by the receive buffer block and its frame shifter
// assumes urb_cfg.svh carries all numeric constants
package urb_pkg;

   typedef enum logic [1:0] {
      URB_IDLE  = 2'b00,
      URB_START = 2'b01,
      URB_BITS  = 2'b10,
      URB_STOP  = 2'b11
   } urb_rx_state_t;

   // one frame as it leaves the shift register
   typedef struct packed {
      logic [8:0] data;
      logic       par_bit;
      logic       stop_bit;
   } urb_frame_t;

   // one receive buffer entry, flags travel with the data
   typedef struct packed {
      logic       fe;
      logic       dor;
      logic       upe;
      logic [8:0] data;
   } urb_entry_t;

endpackage

/* logic/urb_rx_shift.sv */
// frame shifter: start check, data and parity bits, first stop bit
// assumes rx is already synchronised to clk and idles high
`timescale 1ns/1ps
module urb_rx_shift #(
   parameter int DIV_W = 16
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                enable,
   input  wire logic                rx,
   input  wire logic [DIV_W-1:0]    div,
   input  wire logic [3:0]          nbits,
   input  wire logic                par_en,
   output logic                     start_ok,
   output logic                     done,
   output urb_pkg::urb_frame_t      frame
);
   urb_pkg::urb_rx_state_t state_q;
   logic [DIV_W-1:0]       cnt_q;
   logic [3:0]             idx_q;
   logic [9:0]             sh_q;
   logic                   stop_q;
   logic [3:0]             total;
   logic [9:0]             mask;

   assign total = 4'(nbits + {3'h0, par_en});
   assign mask  = (10'h001 << nbits) - 10'h001;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= urb_pkg::URB_IDLE;
         cnt_q    <= '0;
         idx_q    <= 4'h0;
         start_ok <= 1'b0;
         done     <= 1'b0;
      end else begin
         start_ok <= 1'b0;
         done     <= 1'b0;
         if (!enable) begin
            state_q <= urb_pkg::URB_IDLE;
         end else begin
            unique case (state_q)
               urb_pkg::URB_IDLE: begin
                  if (!rx) begin
                     cnt_q   <= div >> 1;
                     state_q <= urb_pkg::URB_START;
                  end
               end
               urb_pkg::URB_START: begin
                  if (cnt_q != '0) begin
                     cnt_q <= cnt_q - 1'b1;
                  end else if (!rx) begin
                     start_ok <= 1'b1;
                     cnt_q    <= div - 1'b1;
                     idx_q    <= 4'h0;
                     state_q  <= urb_pkg::URB_BITS;
                  end else begin
                     state_q <= urb_pkg::URB_IDLE;    // glitch, not a start
                  end
               end
               urb_pkg::URB_BITS: begin
                  if (cnt_q != '0) begin
                     cnt_q <= cnt_q - 1'b1;
                  end else begin
                     cnt_q <= div - 1'b1;
                     idx_q <= idx_q + 4'h1;
                     if (idx_q + 4'h1 == total) begin
                        state_q <= urb_pkg::URB_STOP;
                     end
                  end
               end
               urb_pkg::URB_STOP: begin
                  if (cnt_q != '0) begin
                     cnt_q <= cnt_q - 1'b1;
                  end else begin
                     // only the first stop bit is looked at
                     done    <= 1'b1;
                     state_q <= urb_pkg::URB_IDLE;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q   <= 10'h000;
         stop_q <= 1'b1;
      end else if (state_q == urb_pkg::URB_START) begin
         sh_q <= 10'h000;
      end else if (state_q == urb_pkg::URB_BITS && cnt_q == '0) begin
         sh_q[idx_q] <= rx;
      end else if (state_q == urb_pkg::URB_STOP && cnt_q == '0) begin
         stop_q <= rx;
      end
   end

   assign frame.data     = sh_q[8:0] & mask[8:0];
   assign frame.par_bit  = sh_q[nbits];
   assign frame.stop_bit = stop_q;

endmodule

/* logic/urb_top.sv */
// receive side of a serial port: two-entry buffer, flags, apb registers
// assumes an apb master on CORE_CLK and an asynchronous serial line on RXD_PIN
`timescale 1ns/1ps
`include "urb_cfg.svh"
module urb_top #(
   parameter int DIV_W = 16,
   parameter int DEPTH = 2
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        RXD_PIN,
   output logic             RXD_OVERRIDE,
   output logic             RXC_IRQ
);

   // control state
   logic             irq_en_q;
   logic             rx_en_q;
   logic             tx_ninth_q;
   logic             par_en_q;
   logic             par_odd_q;
   logic             stop_sel_q;
   logic [2:0]       size_q;
   logic [DIV_W-1:0] baud_q;

   // pin synchroniser
   logic             sync1_q;
   logic             sync2_q;
   logic             sync3_q;
   logic             rx_lvl_q;

   // buffer
   urb_pkg::urb_entry_t buf_q [DEPTH];
   logic [$clog2(DEPTH)-1:0] wr_q;
   logic [$clog2(DEPTH)-1:0] rd_q;
   logic [$clog2(DEPTH):0]   cnt_q;
   urb_pkg::urb_entry_t      head;
   logic                     full;
   logic                     nonempty;

   // shift register side
   urb_pkg::urb_entry_t hold_q;
   logic                hold_v_q;
   logic                ovr_pend_q;
   logic                start_ok;
   logic                done;
   urb_pkg::urb_frame_t frame;
   logic [3:0]          nbits;
   logic                upe;
   logic                push;
   logic                load;

   // bus
   logic        setup;
   logic        access;
   logic        mapped;
   logic [31:0] rd_val;
   logic        pop_ok_q;
   logic        pop;

   function automatic logic [3:0] size_bits(input logic [2:0] sz);
      case (sz)
         3'h0:          size_bits = 4'h5;
         3'h1:          size_bits = 4'h6;
         3'h2:          size_bits = 4'h7;
         `URB_SIZE_NINE: size_bits = 4'h9;
         default:       size_bits = 4'h8;
      endcase
   endfunction

   assign nbits    = size_bits(size_q);
   assign full     = cnt_q == ($clog2(DEPTH)+1)'(DEPTH);
   assign nonempty = cnt_q != '0;
   assign head     = buf_q[rd_q];

   // pin sync, a change is taken once the second and third stage agree
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_q  <= 1'b1;
         sync2_q  <= 1'b1;
         sync3_q  <= 1'b1;
         rx_lvl_q <= 1'b1;
      end else begin
         sync1_q <= RXD_PIN;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q) begin
            rx_lvl_q <= sync3_q;
         end
      end
   end

   urb_rx_shift #(
      .DIV_W (DIV_W)
   ) u_shift (
      .clk      (CORE_CLK),
      .rst_n    (RST_N),
      .enable   (rx_en_q),
      .rx       (rx_lvl_q),
      .div      (baud_q),
      .nbits    (nbits),
      .par_en   (par_en_q),
      .start_ok (start_ok),
      .done     (done),
      .frame    (frame)
   );

   // parity result fixed at arrival, disabled checker gives zero
   assign upe = par_en_q &
                (frame.par_bit ^ (^frame.data) ^ par_odd_q);

   // hold register stands for the character waiting in the shifter
   assign push = hold_v_q & ~full & rx_en_q;
   assign load = done & (~hold_v_q | push);

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         hold_v_q <= 1'b0;
         hold_q   <= '0;
      end else if (!rx_en_q) begin
         hold_v_q <= 1'b0;
      end else begin
         if (load) begin
            hold_q.data <= frame.data;
            hold_q.fe   <= ~frame.stop_bit;
            hold_q.upe  <= upe;
            hold_q.dor  <= 1'b0;
            hold_v_q    <= 1'b1;
         end else if (push) begin
            hold_v_q <= 1'b0;
         end
      end
   end

   // overrun: new start while both entries and the shifter are occupied
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ovr_pend_q <= 1'b0;
      end else if (!rx_en_q) begin
         ovr_pend_q <= 1'b0;
      end else if (start_ok & hold_v_q & full) begin
         ovr_pend_q <= 1'b1;
      end else if (push) begin
         ovr_pend_q <= 1'b0;
      end
   end

   // buffer entries; an overrun drops the new frame, stored ones stay
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < DEPTH; i++) begin
            buf_q[i] <= '0;
         end
      end else if (push) begin
         buf_q[wr_q]     <= hold_q;
         buf_q[wr_q].dor <= ovr_pend_q;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (!rx_en_q) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // apb: zero wait states, answer registered in the setup cycle
   assign setup  = PSEL & ~PENABLE;
   assign access = PSEL & PENABLE & PREADY;
   assign mapped = PADDR == `URB_OFS_STATUS || PADDR == `URB_OFS_CTRL_B ||
                   PADDR == `URB_OFS_CTRL_C || PADDR == `URB_OFS_DATA ||
                   PADDR == `URB_OFS_BAUD;
   // pop only what was shown at setup, so a late arrival is not lost
   assign pop    = access & ~PWRITE & (PADDR == `URB_OFS_DATA) & pop_ok_q;

   always_comb begin
      rd_val = 32'h0000_0000;
      case (PADDR)
         `URB_OFS_STATUS: begin
            rd_val[`URB_STA_RXC] = nonempty;
            rd_val[`URB_STA_FE]  = nonempty & head.fe;
            rd_val[`URB_STA_DOR] = nonempty & head.dor;
            rd_val[`URB_STA_UPE] = nonempty & head.upe;
         end
         `URB_OFS_CTRL_B: begin
            rd_val[`URB_CB_IRQ_EN] = irq_en_q;
            rd_val[`URB_CB_RX_EN]  = rx_en_q;
            rd_val[`URB_CB_RX9]    = nonempty & head.data[8];
            rd_val[`URB_CB_TX9]    = tx_ninth_q;
         end
         `URB_OFS_CTRL_C: begin
            rd_val[`URB_CC_PAR_EN]   = par_en_q;
            rd_val[`URB_CC_PAR_ODD]  = par_odd_q;
            rd_val[`URB_CC_STOP_SEL] = stop_sel_q;
            rd_val[`URB_CC_SIZE_LO +: 3] = size_q;
         end
         `URB_OFS_DATA: begin
            rd_val[7:0] = nonempty ? head.data[7:0] : 8'h00;
         end
         `URB_OFS_BAUD: begin
            rd_val[DIV_W-1:0] = baud_q;
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY   <= 1'b0;
         PRDATA   <= 32'h0000_0000;
         PSLVERR  <= 1'b0;
         pop_ok_q <= 1'b0;
      end else begin
         PREADY <= setup;
         if (setup) begin
            PRDATA   <= PWRITE ? 32'h0000_0000 : rd_val;
            PSLVERR  <= ~mapped;
            pop_ok_q <= nonempty;
         end else if (access) begin
            PSLVERR <= 1'b0;
         end
      end
   end

   // status word is read-only: flag writes change nothing
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_en_q   <= 1'b0;
         rx_en_q    <= 1'b0;
         tx_ninth_q <= 1'b0;
         par_en_q   <= 1'b0;
         par_odd_q  <= 1'b0;
         stop_sel_q <= 1'b0;
         size_q     <= `URB_CC_SIZE_RST;
         baud_q     <= `URB_BAUD_RST;
      end else if (access & PWRITE) begin
         unique case (PADDR)
            `URB_OFS_CTRL_B: begin
               irq_en_q   <= PWDATA[`URB_CB_IRQ_EN];
               rx_en_q    <= PWDATA[`URB_CB_RX_EN];
               tx_ninth_q <= PWDATA[`URB_CB_TX9];
            end
            `URB_OFS_CTRL_C: begin
               par_en_q   <= PWDATA[`URB_CC_PAR_EN];
               par_odd_q  <= PWDATA[`URB_CC_PAR_ODD];
               stop_sel_q <= PWDATA[`URB_CC_STOP_SEL];
               size_q     <= PWDATA[`URB_CC_SIZE_LO +: 3];
            end
            `URB_OFS_BAUD: begin
               baud_q <= (PWDATA[DIV_W-1:0] < DIV_W'(2)) ? DIV_W'(2)
                                                         : PWDATA[DIV_W-1:0];
            end
            default: begin
               baud_q <= baud_q;
            end
         endcase
      end
   end

   // level request; error flags take no part in it
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RXC_IRQ      <= 1'b0;
         RXD_OVERRIDE <= 1'b0;
      end else begin
         RXC_IRQ      <= irq_en_q & rx_en_q & (cnt_q != '0)
                         & ~(pop & cnt_q == ($clog2(DEPTH)+1)'(1))
                         | irq_en_q & rx_en_q & push;
         RXD_OVERRIDE <= rx_en_q;
      end
   end

endmodule

/* sim/urb_chk.sv */
// checker for the serial receive buffer block, bound to its top module
// assumes one clock domain and the register map of urb_cfg.svh
`timescale 1ns/1ps
`include "urb_cfg.svh"
module urb_chk #(
   parameter int DIV_W = 16,
   parameter int DEPTH = 2
) (
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        RXD_OVERRIDE,
   input wire logic        RXC_IRQ
);
   logic       acc;
   logic       rd_sta;
   logic       rd_dat;
   logic       irq_en_q;
   logic       rx_en_q;
   logic [2:0] size_q;

   assign acc    = PSEL && PENABLE && PREADY;
   assign rd_sta = acc && !PWRITE && PADDR == `URB_OFS_STATUS;
   assign rd_dat = acc && !PWRITE && PADDR == `URB_OFS_DATA;

   // shadows of control bits, taken at the completing edge of a write
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_en_q <= 1'b0;
         rx_en_q  <= 1'b0;
         size_q   <= `URB_CC_SIZE_RST;
      end else if (acc && PWRITE && PADDR == `URB_OFS_CTRL_B) begin
         irq_en_q <= PWDATA[`URB_CB_IRQ_EN];
         rx_en_q  <= PWDATA[`URB_CB_RX_EN];
      end else if (acc && PWRITE && PADDR == `URB_OFS_CTRL_C) begin
         size_q   <= PWDATA[2:0];
      end
   end

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   a_pin_taken: assert property (RXD_OVERRIDE == $past(rx_en_q))
      else $error("pin override differs from receiver enable");
   a_irq_masked: assert property (!irq_en_q && !$past(irq_en_q) |-> !RXC_IRQ)
      else $error("interrupt raised while its enable is low");
   a_flush_empty: assert property ($fell(rx_en_q) |-> ##2 !RXC_IRQ)
      else $error("buffer not flushed by receiver disable");
   a_status_bits: assert property (rd_sta |-> (PRDATA & 32'hffffff63) == 32'h0)
      else $error("status read shows bits outside the flags");
   a_data_width: assert property (rd_dat |-> PRDATA[31:8] == 24'h0 &&
      (size_q > 3'h3 || (PRDATA[7:0] >> (32'(size_q) + 5)) == 8'h0))
      else $error("unused data bits not zero");
   a_unmapped_err: assert property (acc && PADDR > `URB_OFS_BAUD |-> PSLVERR)
      else $error("unmapped access not refused");
   // status word was taken one edge earlier, compare with the request of that edge
   a_empty_quiet: assert property (rd_sta && !PRDATA[`URB_STA_RXC] |-> !$past(RXC_IRQ))
      else $error("interrupt with empty buffer");
   a_full_irq: assert property (rd_sta && PRDATA[`URB_STA_RXC] && irq_en_q |=> RXC_IRQ)
      else $error("no interrupt with character waiting");

   c_full_status: cover property (rd_sta && PRDATA[`URB_STA_RXC]);
   c_overrun: cover property (rd_sta && PRDATA[`URB_STA_DOR]);
   c_disable: cover property ($fell(rx_en_q));
endmodule

bind urb_top urb_chk #(.DIV_W(DIV_W), .DEPTH(DEPTH)) chk (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD_OVERRIDE(RXD_OVERRIDE), .RXC_IRQ(RXC_IRQ)
);

/* sim/urb_line_model.sv */
// far-end serial transmitter driving the receive pin
// assumes BIT_CYC equals the divisor the bench programs; line idles high
`timescale 1ns/1ps
module urb_line_model #(
   parameter int BIT_CYC = 8
) (
   input  wire logic clk,
   output logic      line
);
   initial line = 1'b1;

   task automatic bit_out(input logic v);
      line <= v;
      repeat (BIT_CYC) @(posedge clk);
   endtask

   // pf flips the parity bit, sv is the first stop bit level
   task automatic send(input logic [8:0] d, input int nb, input logic pe,
                       input logic po, input logic pf, input logic sv);
      logic p;
      p = po ^ pf ^ (^(d & 9'((1 << nb) - 1)));
      bit_out(1'b0);
      for (int i = 0; i < nb; i++) bit_out(d[i]);
      if (pe) bit_out(p);
      bit_out(sv);
      // idle bit so a low stop is not taken for a start
      if (!sv) bit_out(1'b1);
      line <= 1'b1;
   endtask
endmodule

/* sim/tb_uart_receive_buffer_status.sv */
// self-checking bench for the serial receive buffer block over apb
// assumes urb_line_model on the serial pin and urb_chk bound to urb_top
`timescale 1ns/1ps
`include "urb_cfg.svh"
module tb_uart_receive_buffer_status;
   localparam int         BIT_CYC = 8;
   localparam logic [7:0] sta_a   = `URB_OFS_STATUS;
   localparam logic [7:0] ctb_a   = `URB_OFS_CTRL_B;
   localparam logic [7:0] ctc_a   = `URB_OFS_CTRL_C;
   localparam logic [7:0] dat_a   = `URB_OFS_DATA;
   logic        clk     = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rxd;
   logic        rxd_ovr;
   logic        rxc_irq;
   logic [31:0] rd;
   logic        serr;
   logic        pe      = 1'b0;
   logic        po      = 1'b0;
   int          nb      = 8;
   int          n_mismatch  = 0;
   int          comparisons = 0;
   int          cycles      = 0;

   always #50 clk = ~clk;

   urb_top dut (
      .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .RXD_PIN(rxd), .RXD_OVERRIDE(rxd_ovr), .RXC_IRQ(rxc_irq)
   );
   urb_line_model #(.BIT_CYC(BIT_CYC)) far (.clk(clk), .line(rxd));

   task automatic results();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles > 10000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask

   // idle cycle before each setup keeps strobes from toggling in one step
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // no wait count assumed: only the bench timeout ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      check(rd, exp);
   endtask

   task automatic frame(input logic [8:0] d, input logic pf, input logic sv);
      far.send(d, nb, pe, po, pf, sv);
      repeat (12) @(posedge clk);
   endtask

   initial begin
      int sz[5] = '{0, 1, 2, 3, 7};
      int s;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(sta_a, 32'h0);
      rd_chk(ctb_a, 32'h0);
      check({31'h0, rxd_ovr}, 32'h0);
      rd_chk(8'h20, 32'h0);
      check({31'h0, serr}, 32'h1);
      apb(1'b1, `URB_OFS_BAUD, 32'(BIT_CYC));
      apb(1'b1, ctb_a, 32'h90);
      // override is registered one edge after the enable bit
      repeat (2) @(posedge clk);
      check({31'h0, rxd_ovr}, 32'h1);
      frame(9'h0a5, 1'b0, 1'b1);
      check({31'h0, rxc_irq}, 32'h1);
      apb(1'b1, ctb_a, 32'h10);
      repeat (2) @(posedge clk);
      check({31'h0, rxc_irq}, 32'h0);
      apb(1'b1, ctb_a, 32'h90);
      rd_chk(sta_a, 32'h80);
      rd_chk(dat_a, 32'ha5);
      rd_chk(sta_a, 32'h0);
      check({31'h0, rxc_irq}, 32'h0);
      frame(9'h033, 1'b0, 1'b0);
      frame(9'h044, 1'b0, 1'b1);
      apb(1'b1, sta_a, 32'h0);
      rd_chk(sta_a, 32'h90);
      rd_chk(dat_a, 32'h33);
      rd_chk(sta_a, 32'h80);
      rd_chk(dat_a, 32'h44);
      for (int i = 1; i < 5; i++) frame(9'(i), 1'b0, 1'b1);
      rd_chk(sta_a, 32'h80);
      rd_chk(dat_a, 32'h1);
      rd_chk(sta_a, 32'h80);
      rd_chk(dat_a, 32'h2);
      rd_chk(sta_a, 32'h88);
      rd_chk(dat_a, 32'h3);
      frame(9'h066, 1'b0, 1'b1);
      frame(9'h077, 1'b0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, sta_a, 32'h0);
         if (rd[7] === 1'b1) apb(1'b0, dat_a, 32'h0);
      end
      rd_chk(sta_a, 32'h0);
      frame(9'h055, 1'b0, 1'b1);
      rd_chk(sta_a, 32'h80);
      rd_chk(dat_a, 32'h55);
      pe = 1'b1;
      for (int m = 0; m < 2; m++) begin
         po = m[0];
         apb(1'b1, ctc_a, {26'h0, 1'b1, po, 4'h3});
         frame(9'h0b7, 1'b0, 1'b1);
         frame(9'h0b7, 1'b1, 1'b1);
         apb(1'b1, ctc_a, 32'h3);
         rd_chk(sta_a, 32'h80);
         rd_chk(dat_a, 32'hb7);
         rd_chk(sta_a, 32'h84);
         rd_chk(dat_a, 32'hb7);
      end
      pe = 1'b0;
      for (int k = 0; k < 5; k++) begin
         s = sz[k];
         nb = (s == 7) ? 9 : s + 5;
         apb(1'b1, ctc_a, {28'h0, 1'b1, 3'(s)});
         frame(9'h1ff, 1'b0, 1'b1);
         rd_chk(sta_a, 32'h80);
         rd_chk(ctb_a, 32'h90 | {30'h0, s == 7, 1'b0});
         rd_chk(dat_a, (32'h1 << ((nb > 8) ? 8 : nb)) - 32'h1);
      end
      nb = 8;
      apb(1'b1, ctc_a, 32'h3);
      frame(9'h011, 1'b0, 1'b1);
      fork
         far.send(9'h0ff, nb, pe, po, 1'b0, 1'b1);
         begin
            repeat (30) @(posedge clk);
            apb(1'b1, ctb_a, 32'h80);
         end
      join
      check({31'h0, rxd_ovr}, 32'h0);
      check({31'h0, rxc_irq}, 32'h0);
      rd_chk(sta_a, 32'h0);
      apb(1'b1, ctb_a, 32'h90);
      frame(9'h03c, 1'b0, 1'b1);
      rd_chk(sta_a, 32'h80);
      rd_chk(dat_a, 32'h3c);
      results();
   end
endmodule
